// >>> freq_profile_chk.sv
module freq_profile_chk
    import freq_profile_pkg::*;
#(
    parameter longint reset_pulse_len = 20, // Pulse length in cycles
    parameter int step_size = 32'h0000_0100 // Largest slew step
) (
    input wire logic clk, // Reference clock
    input wire logic arst_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic [31:0] feedback_word, // Slewed divider word
    input wire logic overshoot_limiting, // Slewing
    input wire logic single_ended_out1_run, // First output gate
    input wire logic differential_out1_run, // Differential gate
    input wire logic slow_clk_out, // 32 kHz level
    input wire logic reset_out, // Reset pulse
    input wire logic reset_out_oe, // Reset drive enable
    input wire logic core_powered // Low in powerdown
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    longint hi_cnt;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hi_cnt <= 0;
        end else begin
            hi_cnt <= reset_out ? hi_cnt + 1 : 0;
        end
    end
    chk_ready_access: assert property ((psel && penable) |-> pready)
        else $error("access cycle without ready");
    chk_ready_cause: assert property (pready |-> (psel && penable))
        else $error("ready outside an access cycle");
    chk_err_unmapped: assert property ((pready && paddr >= 8'h20) |-> (pslverr && prdata == 0))
        else $error("unmapped access not refused");
    chk_pulse_len: assert property ($fell(reset_out) |-> hi_cnt == reset_pulse_len)
        else $error("reset pulse length wrong");
    chk_pulse_single: assert property ($fell(reset_out) |=> !reset_out [*8])
        else $error("reset pulse repeated");
    chk_slew_only: assert property ($changed(feedback_word) |->
        (overshoot_limiting || $past(overshoot_limiting)))
        else $error("divider word moved outside slewing");
    chk_step_size: assert property ($changed(feedback_word) |->
        ((feedback_word - $past(feedback_word)) <= 32'(step_size) ||
        ($past(feedback_word) - feedback_word) <= 32'(step_size)))
        else $error("divider word jumped");
    chk_pd_gates: assert property (!core_powered |->
        (!single_ended_out1_run && !differential_out1_run))
        else $error("output running in powerdown");
    chk_slow_half: assert property ($changed(slow_clk_out) |=>
        $stable(slow_clk_out) [*8])
        else $error("slow clock toggles too fast");
    // Drive enable follows the register one edge after the write lands
    chk_oe_cause: assert property ($changed(reset_out_oe) |->
        $past(psel && penable && pwrite && paddr == timer_offset, 2))
        else $error("reset drive enable changed without write");
    cover property ($rose(reset_out));
    cover property ($fell(core_powered));
    cover property ($rose(overshoot_limiting));
    cover property (pready && pslverr);
endmodule : freq_profile_chk

bind freq_profile_timer_ctrl freq_profile_chk #(
    .reset_pulse_len(reset_pulse_len),
    .step_size(step_size)
) u_chk (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .feedback_word(feedback_word), .overshoot_limiting(overshoot_limiting),
    .single_ended_out1_run(single_ended_out1_run), .differential_out1_run(differential_out1_run),
    .slow_clk_out(slow_clk_out), .reset_out(reset_out), .reset_out_oe(reset_out_oe),
    .core_powered(core_powered)
);

// >>> freq_profile_pkg.sv
package freq_profile_pkg;
    // APB register byte offsets
    localparam logic [7:0] ctrl_offset = 8'h00;
    localparam logic [7:0] pin_cfg_offset = 8'h04;
    localparam logic [7:0] timer_offset = 8'h08;
    localparam logic [7:0] out_en_offset = 8'h0C;
    localparam logic [7:0] cfg_target_offset = 8'h10;
    localparam logic [7:0] profile_data_offset = 8'h14;
    localparam logic [7:0] status_offset = 8'h18;
    localparam logic [7:0] active_word_offset = 8'h1C;
    // ctrl fields
    localparam int freq_ctrl_enable_pos = 4;
    localparam int reg_profile_lsb = 0;
    // pin_cfg fields
    localparam int pin1_sel_lsb = 5;
    localparam int pin3_sel_lsb = 2;
    localparam int strap_pos = 0;
    // timer fields
    localparam int timer_enable_pos = 0;
    localparam int timer_sel_lsb = 1;
    localparam int reset_out_enable_pos = 3;
    localparam int reset_pin_sel_pos = 4;
    // out_en fields
    localparam int bus_oe_pos = 0;
    localparam int se1_en_pos = 1;
    localparam int differential_out1_en_pos = 2;
    localparam int slow_clk_en_pos = 3;
    // cfg_target fields
    localparam int cfg_target_lsb = 2;
    // status fields
    localparam int timeout_flag_pos = 0;
    localparam int reset_pulse_pos = 1;
    localparam int slewing_pos = 2;
    localparam int active_profile_lsb = 4;
    // Pin function codes
    localparam logic [1:0] fn_output_enable = 2'b00;
    localparam logic [1:0] fn_powerdown = 2'b01;
    localparam logic [1:0] fn_saving_monitor = 2'b10;
    localparam logic [1:0] fn_profile_select = 2'b11;
    localparam logic [31:0] reset_word = 32'h0000_0000;
    // Timing
    localparam longint clk_hz = 100_000_000;
    localparam longint timeout_base_ms = 500;
    localparam longint reset_pulse_ms = 250;
    localparam longint slow_clk_hz = 32_768;
    localparam longint timeout_base_cycles = clk_hz * timeout_base_ms / 1000;
    localparam longint reset_pulse_cycles = clk_hz * reset_pulse_ms / 1000;
    localparam longint slow_half_cycles = clk_hz / (2 * slow_clk_hz);
    typedef enum logic [1:0] {
        idle_type_st,
        slew_type_st,
        settle_type_st
    } slew_state_type;
endpackage : freq_profile_pkg

// >>> freq_profile_timer_ctrl.sv
// What this block does
// - Four stored divider profiles, index picks one
// - Profile change applies overshoot limiting automatically
// - Enable off forces zero; pins are ignored
// - Pin3 alone selecting profiles is unsupported
// - Strap zero: serial pins give index
// - Strap one: register field gives index
// - Target field picks profile for writes
// - Setting writes stored into targeted profile
// - Frequency steps gradually toward new target
// - Monitor pin switches output to 32 kHz
// - Enable pins default to output enable
// - Timer periods 0.5, 1, 2, 4 seconds
// - Timeout flag held until enable cleared
// - Expiry emits single 250 ms reset pulse
// - Expiry returns profile zero, then disables
// - Pin1 enable gates only first single-ended output
// - Powerdown low stops all but 32 kHz
// - Output runs when powerdown, bus and own enable
module freq_profile_timer_ctrl
    import freq_profile_pkg::*;
#(
    parameter longint timeout_base = timeout_base_cycles, // Cycles for 0.5 s
    parameter longint reset_pulse_len = reset_pulse_cycles, // Cycles for 250 ms
    parameter int step_size = 32'h0000_0100, // Slew step per enable
    parameter int step_div = 16 // Cycles between slew steps
) (
    input wire logic clk, // 100 MHz reference
    input wire logic arst_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic enable_pin1, // Multi-function pin 1
    input wire logic enable_pin3, // Multi-function pin 3 (absent in package)
    input wire logic clock_pin_profile_bit1, // Serial clock pin level
    input wire logic data_pin_profile_bit0, // Serial data pin level
    output logic [31:0] feedback_word, // Slewed divider word to loop two
    output logic overshoot_limiting, // High while slewing
    output logic single_ended_out1_run, // First single-ended output gate
    output logic single_ended_out1_slow, // Output switched to 32 kHz
    output logic differential_out1_run, // Differential output gate
    output logic slow_clk_out, // 32 kHz clock level
    output logic reset_out, // Reset output level
    output logic reset_out_oe, // Reset output drive enable
    output logic core_powered // Low in global powerdown
);
    if (step_div < 1 || timeout_base < 1
        || reset_pulse_len < 1 || step_size < 1) begin : bad_param
        $error("freq_profile_timer_ctrl: bad parameter");
    end

    logic [31:0] ctrl, pin_cfg, timer_cfg, out_en, cfg_target;
    logic [31:0] profiles [4];
    logic sync1, sync1b, sync3, sync3b, syncc, synccb, syncd, syncdb;
    logic strap;
    logic [1:0] strap_wait;
    logic timeout_flag;
    logic pulse_active;
    logic [1:0] active_index;
    logic [1:0] next_index;
    logic [63:0] timer_count;
    logic [63:0] pulse_count;
    logic [31:0] step_count;
    logic [31:0] slow_count;
    slew_state_type slew_state;

    wire logic [1:0] pin1_fn = pin_cfg[pin1_sel_lsb +: 2];
    wire logic [1:0] pin3_fn = pin_cfg[pin3_sel_lsb +: 2];
    wire logic pin1 = sync1b;
    wire logic pin3 = sync3b;
    wire logic write_en = psel && penable && pwrite;
    wire logic timer_en = timer_cfg[timer_enable_pos];
    wire logic [63:0] timeout_limit = timeout_base << timer_cfg[timer_sel_lsb +: 2];
    wire logic expire = timer_en && !timeout_flag && (timer_count + 64'd1 >= timeout_limit);
    wire logic powered = !(pin1_fn == fn_powerdown && !pin1);
    wire logic [31:0] status_word = {24'h00_0000, 2'b00, active_index, 1'b0,
        slew_state != idle_type_st, pulse_active, timeout_flag};

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
        addr_hit = a == off;
    endfunction : addr_hit

    // Two stages for every pin input; stage one feeds stage two only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= 1'b0;
            sync3 <= 1'b0;
            syncc <= 1'b0;
            syncd <= 1'b0;
            sync1b <= 1'b0;
            sync3b <= 1'b0;
            synccb <= 1'b0;
            syncdb <= 1'b0;
        end else begin
            sync1 <= enable_pin1;
            sync3 <= enable_pin3;
            syncc <= clock_pin_profile_bit1;
            syncd <= data_pin_profile_bit0;
            sync1b <= sync1;
            sync3b <= sync3;
            synccb <= syncc;
            syncdb <= syncd;
        end
    end

    // Strap is caught on the third edge after release; earlier the
    // synchroniser still holds its reset level, not the pin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strap <= 1'b0;
            strap_wait <= 2'b00;
        end else if (strap_wait != 2'b11) begin
            strap <= synccb;
            strap_wait <= strap_wait + 2'b01;
        end
    end

    // Profile index priority
    always_comb begin
        next_index = 2'b00;
        if (!ctrl[freq_ctrl_enable_pos]) begin
            next_index = 2'b00;
        end else if (timeout_flag) begin
            next_index = 2'b00; // Expiry returns to profile zero
        end else if (pin1_fn == fn_profile_select) begin
            next_index = {(pin3_fn == fn_profile_select) && pin3, pin1};
        end else if (pin3_fn == fn_profile_select) begin
            next_index = active_index; // Unsupported mix holds the index
        end else if (!strap) begin
            next_index = {synccb, syncdb};
        end else begin
            next_index = ctrl[reg_profile_lsb +: 2];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            active_index <= 2'b00;
        end else begin
            active_index <= next_index;
        end
    end

    // Register writes; pin functions reset to output enable
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= reset_word;
            pin_cfg <= reset_word;
            timer_cfg <= reset_word;
            out_en <= reset_word;
            cfg_target <= reset_word;
        end else begin
            if (write_en) begin
                if (addr_hit(paddr, ctrl_offset)) begin
                    ctrl <= pwdata & 32'h0000_0013;
                end else if (addr_hit(paddr, pin_cfg_offset)) begin
                    pin_cfg <= pwdata & 32'h0000_006C; // Code 10 picks monitor
                end else if (addr_hit(paddr, timer_offset)) begin
                    timer_cfg <= pwdata & 32'h0000_001F;
                end else if (addr_hit(paddr, out_en_offset)) begin
                    out_en <= pwdata & 32'h0000_000F;
                end else if (addr_hit(paddr, cfg_target_offset)) begin
                    cfg_target <= pwdata & 32'h0000_000C;
                end
            end
            // Disable once the reset pulse has ended
            if (ctrl[freq_ctrl_enable_pos] && timeout_flag && !pulse_active
                && !(write_en && addr_hit(paddr, ctrl_offset))) begin
                ctrl[freq_ctrl_enable_pos] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 4; i++) begin
                profiles[i] <= reset_word;
            end
        end else if (write_en && addr_hit(paddr, profile_data_offset)) begin
            profiles[cfg_target[cfg_target_lsb +: 2]] <= pwdata;
        end
    end

    // APB answers in the access cycle; no wait states
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= reset_word;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= reset_word;
                if (addr_hit(paddr, ctrl_offset)) begin
                    prdata <= ctrl;
                end else if (addr_hit(paddr, pin_cfg_offset)) begin
                    prdata <= pin_cfg | {31'h0000_0000, strap};
                end else if (addr_hit(paddr, timer_offset)) begin
                    prdata <= timer_cfg;
                end else if (addr_hit(paddr, out_en_offset)) begin
                    prdata <= out_en;
                end else if (addr_hit(paddr, cfg_target_offset)) begin
                    prdata <= cfg_target;
                end else if (addr_hit(paddr, profile_data_offset)) begin
                    prdata <= profiles[cfg_target[cfg_target_lsb +: 2]];
                end else if (addr_hit(paddr, status_offset)) begin
                    prdata <= status_word;
                end else if (addr_hit(paddr, active_word_offset)) begin
                    prdata <= feedback_word;
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // Timer and sticky flag; flag only clears with timer enable low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_count <= 64'd0;
            timeout_flag <= 1'b0;
        end else if (!timer_en) begin
            timer_count <= 64'd0;
            timeout_flag <= 1'b0;
        end else if (expire) begin
            timeout_flag <= 1'b1;
        end else if (!timeout_flag) begin
            timer_count <= timer_count + 64'd1;
        end
    end

    // One reset pulse per expiry
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse_active <= 1'b0;
            pulse_count <= 64'd0;
        end else if (expire && timer_cfg[reset_out_enable_pos]) begin
            pulse_active <= 1'b1;
            pulse_count <= 64'd0;
        end else if (pulse_active) begin
            pulse_count <= pulse_count + 64'd1;
            if (pulse_count + 64'd1 >= reset_pulse_len) begin
                pulse_active <= 1'b0;
            end
        end
    end

    // Slew the divider word toward the chosen profile in fixed steps;
    // expiry with control on already drives the index to zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            feedback_word <= reset_word;
            slew_state <= idle_type_st;
            step_count <= 32'd0;
            overshoot_limiting <= 1'b0;
        end else begin
            case (slew_state)
                idle_type_st: begin
                    overshoot_limiting <= 1'b0;
                    if (feedback_word != profiles[active_index]) begin
                        slew_state <= slew_type_st;
                        overshoot_limiting <= 1'b1;
                        step_count <= 32'd0;
                    end
                end
                slew_type_st: begin
                    if (step_count + 32'd1 >= 32'(step_div)) begin
                        step_count <= 32'd0;
                        if (feedback_word < profiles[active_index]) begin
                            if (profiles[active_index] - feedback_word <= 32'(step_size))
                                feedback_word <= profiles[active_index];
                            else
                                feedback_word <= feedback_word + 32'(step_size);
                        end else if (feedback_word > profiles[active_index]) begin
                            if (feedback_word - profiles[active_index] <= 32'(step_size))
                                feedback_word <= profiles[active_index];
                            else
                                feedback_word <= feedback_word - 32'(step_size);
                        end else begin
                            slew_state <= settle_type_st;
                        end
                    end else begin
                        step_count <= step_count + 32'd1;
                    end
                end
                settle_type_st: begin
                    slew_state <= idle_type_st;
                end
                default: slew_state <= idle_type_st;
            endcase
        end
    end

    // 32 kHz enable divider keeps running even in powerdown
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            slow_count <= 32'd0;
            slow_clk_out <= 1'b0;
        end else if (slow_count + 32'd1 >= 32'(slow_half_cycles)) begin
            slow_count <= 32'd0;
            slow_clk_out <= !slow_clk_out && out_en[slow_clk_en_pos];
        end else begin
            slow_count <= slow_count + 32'd1;
        end
    end

    // Output gating
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            single_ended_out1_run <= 1'b0;
            single_ended_out1_slow <= 1'b0;
            differential_out1_run <= 1'b0;
            core_powered <= 1'b1;
            reset_out <= 1'b0;
            reset_out_oe <= 1'b0;
        end else begin
            core_powered <= powered;
            single_ended_out1_run <= powered && out_en[bus_oe_pos] && out_en[se1_en_pos]
                && !(pin1_fn == fn_output_enable && !pin1);
            single_ended_out1_slow <= pin1_fn == fn_saving_monitor && !pin1;
            differential_out1_run <= powered && out_en[bus_oe_pos]
                && out_en[differential_out1_en_pos];
            reset_out <= pulse_active;
            reset_out_oe <= timer_cfg[reset_pin_sel_pos];
        end
    end
endmodule : freq_profile_timer_ctrl

// >>> host_pins_model.sv
module host_pins_model (
    input wire logic clk, // Reference clock
    input wire logic slow, // High: host answers four cycles late
    input wire logic [3:0] want, // Requested levels: data, clock, pin3, pin1
    output logic enable_pin1, // Multi-function pin 1
    output logic enable_pin3, // Multi-function pin 3
    output logic clock_pin_profile_bit1, // Serial clock pin, idles high
    output logic data_pin_profile_bit0 // Serial data pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] pipe [4];
    // Levels move only just after an edge and then hold until the next request
    always_ff @(posedge clk) begin
        pipe[0] <= want;
        pipe[1] <= pipe[0];
        pipe[2] <= pipe[1];
        pipe[3] <= pipe[2];
    end
    assign {data_pin_profile_bit0, clock_pin_profile_bit1, enable_pin3, enable_pin1} =
        slow ? pipe[3] : pipe[0];
endmodule : host_pins_model

// >>> tb_top.sv
module tb_top
    import freq_profile_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam longint tbase = 100;
    localparam longint plen = 20;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, err, slow, s0;
    logic pin1, pin3, cpin, dpin, olim, se_run, se_slow, df_run, sclk, rout, rout_oe, corep;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, fword, rd;
    logic [3:0] want;
    int errors, cmp_count, n;
    freq_profile_timer_ctrl #(.timeout_base(tbase), .reset_pulse_len(plen)) dut (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .enable_pin1(pin1), .enable_pin3(pin3), .clock_pin_profile_bit1(cpin),
        .data_pin_profile_bit0(dpin), .feedback_word(fword), .overshoot_limiting(olim),
        .single_ended_out1_run(se_run), .single_ended_out1_slow(se_slow),
        .differential_out1_run(df_run), .slow_clk_out(sclk), .reset_out(rout),
        .reset_out_oe(rout_oe), .core_powered(corep));
    host_pins_model host (.clk(clk), .slow(slow), .want(want), .enable_pin1(pin1),
        .enable_pin3(pin3), .clock_pin_profile_bit1(cpin), .data_pin_profile_bit0(dpin));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic chkb(input string what, input logic seen, input logic exp);
        check(what, {31'b0, seen}, {31'b0, exp});
    endtask : chkb
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chkb("pready", pready, 1'b1);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdx(input string what, input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, rd & m, exp);
    endtask : rdx
    // Polls status until the active index shows up, then compares it
    task automatic idx_is(input logic [1:0] idx);
        int k;
        k = 0;
        do begin
            apb(1'b0, status_offset, 32'h0000_0000);
            k++;
        end while (rd[active_profile_lsb +: 2] !== idx && k < 20);
        check("active index", {30'b0, rd[active_profile_lsb +: 2]}, {30'b0, idx});
    endtask : idx_is
    task automatic settle;
        int k;
        k = 0;
        while (olim !== 1'b0 && k < 20000) begin
            @(posedge clk);
            k++;
        end
    endtask : settle
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        $display("ERROR watchdog expired");
        give_verdict();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, slow, arst_n} = '0;
        want = 4'b1101;
        errors = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chkb("core powered", corep, 1'b1);
        rdx("pin config", pin_cfg_offset, 32'hFFFF_FFFF, 32'h0000_0001);
        rdx("unmapped", 8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
        chkb("pslverr", err, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wr(cfg_target_offset, i << cfg_target_lsb);
            wr(profile_data_offset, 32'h0000_1000 * (i + 1));
        end
        for (int i = 3; i >= 0; i--) begin
            wr(cfg_target_offset, i << cfg_target_lsb);
            rdx("slot", profile_data_offset, '1, 32'h0000_1000 * (i + 1));
        end
        $display("test profiles done");
        wr(ctrl_offset, 32'h0000_0012);
        idx_is(2'd2);
        chkb("slewing", olim, 1'b1);
        repeat (100) @(posedge clk);
        chkb("gradual", fword > 0 && fword < 32'h0000_3000, 1'b1);
        settle();
        check("feedback", fword, 32'h0000_3000);
        rdx("active word", active_word_offset, '1, 32'h0000_3000);
        wr(pin_cfg_offset, 32'h0000_0060);
        idx_is(2'd1);
        slow <= 1'b1;
        wr(pin_cfg_offset, 32'h0000_006C);
        want[1] <= 1'b1;
        idx_is(2'd3);
        want[0] <= 1'b0;
        idx_is(2'd2);
        // Register field 1 must not leak through while the index is held
        wr(ctrl_offset, 32'h0000_0011);
        wr(pin_cfg_offset, 32'h0000_000C);
        want[1] <= 1'b0;
        repeat (12) @(posedge clk);
        idx_is(2'd2);
        wr(ctrl_offset, 32'h0000_0000);
        idx_is(2'd0);
        settle();
        $display("test index sources done");
        slow <= 1'b0;
        wr(pin_cfg_offset, 32'h0000_0000);
        wr(out_en_offset, 32'h0000_000F);
        want[0] <= 1'b1;
        repeat (10) @(posedge clk);
        chkb("se1 run", se_run, 1'b1);
        want[0] <= 1'b0;
        repeat (10) @(posedge clk);
        chkb("se1 gated", se_run, 1'b0);
        chkb("differential_out1 untouched", df_run, 1'b1);
        wr(pin_cfg_offset, 32'h0000_0020);
        repeat (10) @(posedge clk);
        chkb("powerdown core", corep, 1'b0);
        chkb("powerdown differential_out1", df_run, 1'b0);
        s0 = sclk;
        n = 0;
        while (sclk === s0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        chkb("slow clock runs", sclk !== s0, 1'b1);
        want[0] <= 1'b1;
        wr(out_en_offset, 32'h0000_000E);
        repeat (10) @(posedge clk);
        chkb("bus oe off", se_run | df_run, 1'b0);
        wr(out_en_offset, 32'h0000_000F);
        wr(pin_cfg_offset, 32'h0000_0040);
        want[0] <= 1'b0;
        repeat (10) @(posedge clk);
        chkb("monitor slow", se_slow, 1'b1);
        want[0] <= 1'b1;
        repeat (10) @(posedge clk);
        chkb("monitor normal", se_slow, 1'b0);
        $display("test outputs done");
        wr(ctrl_offset, 32'h0000_0011);
        idx_is(2'd1);
        for (int s = 0; s < 4; s++) begin
            wr(timer_offset, 32'h0000_0000);
            wr(timer_offset, 32'h0000_0019 | (s << timer_sel_lsb));
            n = 0;
            while (rout !== 1'b1 && n < 2000) begin
                @(posedge clk);
                n++;
            end
            chkb("timeout", n >= (tbase << s) - 8 && n <= (tbase << s) + 8, 1'b1);
            chkb("reset drive", rout_oe, 1'b1);
            n = 0;
            while (rout === 1'b1 && n < 200) begin
                @(posedge clk);
                n++;
            end
            chkb("pulse length", n >= plen - 1 && n <= plen + 1, 1'b1);
            rdx("flag", status_offset, 32'h0000_0031, 32'h0000_0001);
            rdx("control off", ctrl_offset, 32'h0000_0010, 32'h0000_0000);
            wr(timer_offset, 32'h0000_0000);
            rdx("flag cleared", status_offset, 32'h0000_0001, 32'h0000_0000);
        end
        $display("test timer done");
        want <= 4'b1001;
        arst_n <= 1'b0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rdx("strap low", pin_cfg_offset, 32'h0000_0001, 32'h0000_0000);
        wr(ctrl_offset, 32'h0000_0010);
        want <= 4'b0101;
        idx_is(2'd2);
        $display("test serial pins done");
        give_verdict();
    end
endmodule : tb_top
